// [rtl/nvm_ctrl_pkg.sv]
package nvm_ctrl_pkg;
  // Byte offsets on the register port
  localparam logic [7:0] OFF_DIV_HIGH = 8'hEE;
  localparam logic [7:0] OFF_DIV_LOW = 8'hEF;
  localparam logic [7:0] OFF_MODULE_CONFIG = 8'hF0;
  localparam logic [7:0] OFF_BLOCK_PROTECT = 8'hF1;
  localparam logic [7:0] OFF_PROGRAM_CONTROL = 8'hF3;
  // Array address map
  localparam logic [11:0] ARRAY_BASE = 12'hC00;
  localparam logic [11:0] ARRAY_TOP = 12'hFFF;
  localparam logic [11:0] SHADOW_ADDR_HIGH = 12'hFC0;
  localparam logic [11:0] SHADOW_ADDR_LOW = 12'hFC1;
  localparam logic [11:0] BLK4_LO = 12'hC00;
  localparam logic [11:0] BLK4_HI = 12'hDFF;
  localparam logic [11:0] BLK3_LO = 12'hE00;
  localparam logic [11:0] BLK3_HI = 12'hEFF;
  localparam logic [11:0] BLK2_LO = 12'hF00;
  localparam logic [11:0] BLK2_HI = 12'hF7F;
  localparam logic [11:0] BLK1_LO = 12'hF80;
  localparam logic [11:0] BLK1_HI = 12'hFBF;
  localparam logic [11:0] BLK0_LO = 12'hFC0;
  localparam logic [11:0] BLK0_HI = 12'hFFF;
  // Module config bit positions
  localparam int MC_DEBUG_LOCKOUT_DISABLE = 7;
  localparam int MC_SHADOW_HIDE = 6;
  localparam int MC_TEST = 5;
  localparam int MC_FLASH_OPEN = 4;
  localparam int MC_STOP_IN_WAIT = 2;
  localparam int MC_PROTECT_LOCK = 1;
  localparam int MC_SPARE = 0;
  // Program control bit positions
  localparam int PC_BULK_PROTECT = 7;
  localparam int PC_SELF_CLEAR = 5;
  localparam int PC_SINGLE = 4;
  localparam int PC_ROW = 3;
  localparam int PC_ERASE = 2;
  localparam int PC_LATCH = 1;
  localparam int PC_HV = 0;
  // Block protect bit positions
  localparam int BP_SHADOW_PROTECT = 7;
  // Reset values of the fixed bits, and the writable masks
  localparam logic [3:0] MC_LOW_RESET = 4'hC;
  localparam logic [7:0] BLOCK_PROTECT_RESET = 8'h9F;
  localparam logic [7:0] PROGRAM_CONTROL_RESET = 8'h80;
  localparam logic [7:0] PC_WRITABLE_MASK = 8'hBF;
  localparam logic [7:0] BP_WRITABLE_MASK = 8'h9F;
  // Self-time base: one tick per divider count of clk_i cycles
  localparam int PROGRAM_DELAY_MS = 10;
  localparam int TICK_US = 35;
  localparam int PROGRAM_DELAY_TICKS = (PROGRAM_DELAY_MS * 1000 + TICK_US - 1) / TICK_US;

  typedef enum logic [1:0] {OP_PROGRAM, OP_BULK, OP_ROW, OP_SINGLE} op_kind_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] data;
    logic word;
  } latch_t;

  typedef struct packed {
    logic [7:0] module_config;
    logic [7:0] block_protect;
    logic [7:0] program_control;
    logic [9:0] divider;
    logic divider_written;
    logic lock_written;
    logic flash_open_written;
    logic latch_loaded;
    latch_t latch;
    logic [9:0] prescale;
    logic [9:0] ticks;
    logic cycle_active;
    logic cycle_done;
    logic [7:0] rdata;
    logic loaded;
  } state_t;
endpackage

// [rtl/nvm_program_erase_ctrl.sv]
`timescale 1ns/1ps
module nvm_program_erase_ctrl (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic normal_mode_flag_i,
  input wire logic wait_mode_i,
  input wire logic [15:0] shadow_word_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [11:0] arr_addr_i,
  input wire logic [15:0] arr_wdata_i,
  input wire logic arr_wr_i,
  input wire logic arr_word_i,
  output logic shadow_select_o,
  output logic arr_write_accept_o,
  output logic hv_on_o,
  output logic [1:0] op_kind_o,
  output logic [11:0] op_addr_o,
  output logic [15:0] op_data_o,
  output logic op_word_o,
  output logic module_clk_en_o,
  output logic flash_program_open_o,
  output logic debug_lockout_disable_o
);
  nvm_ctrl_pkg::state_t s_q;
  nvm_ctrl_pkg::state_t s_d;
  logic mode_n_meta_q;
  logic mode_n_q;
  logic [7:0] pc_new;
  logic hv;
  logic shadow_vis;
  logic protected_target;
  logic [1:0] kind;
  logic blk_hit;
  logic [4:0] blk_hits;

  // Mode pin is asynchronous to the bus clock
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_n_meta_q <= 1'b1;
      mode_n_q <= 1'b1;
    end
    else
    begin
      mode_n_meta_q <= normal_mode_flag_i;
      mode_n_q <= mode_n_meta_q;
    end
  end

  assign hv = s_q.program_control[nvm_ctrl_pkg::PC_HV];
  assign shadow_vis = !s_q.module_config[nvm_ctrl_pkg::MC_SHADOW_HIDE];

  always_comb
  begin
    if (!s_q.program_control[nvm_ctrl_pkg::PC_ERASE])
      kind = nvm_ctrl_pkg::OP_PROGRAM;
    else if (s_q.program_control[nvm_ctrl_pkg::PC_SINGLE])
      kind = nvm_ctrl_pkg::OP_SINGLE;
    else if (s_q.program_control[nvm_ctrl_pkg::PC_ROW])
      kind = nvm_ctrl_pkg::OP_ROW;
    else
      kind = nvm_ctrl_pkg::OP_BULK;
  end

  // one window per block protect bit 4 to 0
  // Windows watch the latched target, which high voltage freezes
  nvm_range_hit #(
    .LO(nvm_ctrl_pkg::BLK4_LO),
    .HI(nvm_ctrl_pkg::BLK4_HI)
  ) u_blk4 (
    .addr_i(s_q.latch.addr),
    .en_i(s_q.block_protect[4]),
    .hit_o(blk_hits[4])
  );

  nvm_range_hit #(
    .LO(nvm_ctrl_pkg::BLK3_LO),
    .HI(nvm_ctrl_pkg::BLK3_HI)
  ) u_blk3 (
    .addr_i(s_q.latch.addr),
    .en_i(s_q.block_protect[3]),
    .hit_o(blk_hits[3])
  );

  nvm_range_hit #(
    .LO(nvm_ctrl_pkg::BLK2_LO),
    .HI(nvm_ctrl_pkg::BLK2_HI)
  ) u_blk2 (
    .addr_i(s_q.latch.addr),
    .en_i(s_q.block_protect[2]),
    .hit_o(blk_hits[2])
  );

  nvm_range_hit #(
    .LO(nvm_ctrl_pkg::BLK1_LO),
    .HI(nvm_ctrl_pkg::BLK1_HI)
  ) u_blk1 (
    .addr_i(s_q.latch.addr),
    .en_i(s_q.block_protect[1]),
    .hit_o(blk_hits[1])
  );

  nvm_range_hit #(
    .LO(nvm_ctrl_pkg::BLK0_LO),
    .HI(nvm_ctrl_pkg::BLK0_HI)
  ) u_blk0 (
    .addr_i(s_q.latch.addr),
    .en_i(s_q.block_protect[0]),
    .hit_o(blk_hits[0])
  );

  assign blk_hit = |blk_hits;

  // Any of block bits 4 to 0 set protects the whole array from bulk erase; row erase checks the bulk protect bit and only the window of its target
  always_comb
  begin
    logic shadow_target;
    shadow_target = shadow_vis && (s_q.latch.addr == nvm_ctrl_pkg::SHADOW_ADDR_HIGH
                                || s_q.latch.addr == nvm_ctrl_pkg::SHADOW_ADDR_LOW);
    protected_target = 1'b0;
    case (kind)
      nvm_ctrl_pkg::OP_PROGRAM, nvm_ctrl_pkg::OP_SINGLE:
      begin
        if (shadow_target)
          // Shadow protect sits in the top bit, apart from the five windows
          protected_target = s_q.block_protect[nvm_ctrl_pkg::BP_SHADOW_PROTECT];
        else
          protected_target = blk_hit;
      end
      nvm_ctrl_pkg::OP_ROW:
        protected_target = s_q.program_control[nvm_ctrl_pkg::PC_BULK_PROTECT] || blk_hit;
      nvm_ctrl_pkg::OP_BULK:
        protected_target = s_q.program_control[nvm_ctrl_pkg::PC_BULK_PROTECT]
                        || !shadow_vis || (s_q.block_protect[4:0] != 5'h00);
      default:
        protected_target = 1'b1;
    endcase
    // Nothing latched yet: treat as protected so no empty cycle runs
    if (!s_q.latch_loaded)
      protected_target = 1'b1;
  end

  always_comb
  begin
    logic wr_mc;
    logic wr_bp;
    logic wr_pc;
    logic wr_dh;
    logic wr_dl;
    logic special;
    logic tick;
    logic [7:0] w;
    wr_mc = reg_wr_i && reg_addr_i == nvm_ctrl_pkg::OFF_MODULE_CONFIG;
    wr_bp = reg_wr_i && reg_addr_i == nvm_ctrl_pkg::OFF_BLOCK_PROTECT;
    wr_pc = reg_wr_i && reg_addr_i == nvm_ctrl_pkg::OFF_PROGRAM_CONTROL;
    wr_dh = reg_wr_i && reg_addr_i == nvm_ctrl_pkg::OFF_DIV_HIGH;
    wr_dl = reg_wr_i && reg_addr_i == nvm_ctrl_pkg::OFF_DIV_LOW;
    special = !mode_n_q;
    w = reg_wdata_i;
    s_d = s_q;
    pc_new = s_q.program_control;
    tick = 1'b0;

    // Shadow load one cycle after reset release
    if (!s_q.loaded)
    begin
      s_d.loaded = 1'b1;
      s_d.module_config[7:4] = shadow_word_i[15:12];
      s_d.divider = {shadow_word_i[9:8], shadow_word_i[7:0]};
    end
    else
    begin
      if (wr_mc)
      begin
        if (special)
          s_d.module_config[7:6] = w[7:6];
        if (special)
          s_d.module_config[nvm_ctrl_pkg::MC_FLASH_OPEN] = w[nvm_ctrl_pkg::MC_FLASH_OPEN];
        else if (!s_q.flash_open_written && !w[nvm_ctrl_pkg::MC_FLASH_OPEN])
        begin
          s_d.module_config[nvm_ctrl_pkg::MC_FLASH_OPEN] = 1'b0;
          s_d.flash_open_written = 1'b1;
        end
        s_d.module_config[nvm_ctrl_pkg::MC_STOP_IN_WAIT] = w[nvm_ctrl_pkg::MC_STOP_IN_WAIT];
        s_d.module_config[nvm_ctrl_pkg::MC_SPARE] = w[nvm_ctrl_pkg::MC_SPARE];
        if (special || !s_q.lock_written)
        begin
          s_d.module_config[nvm_ctrl_pkg::MC_PROTECT_LOCK] = w[nvm_ctrl_pkg::MC_PROTECT_LOCK];
          s_d.lock_written = !special;
        end
      end
      if (wr_bp && !hv && !s_q.module_config[nvm_ctrl_pkg::MC_PROTECT_LOCK])
        s_d.block_protect = w & nvm_ctrl_pkg::BP_WRITABLE_MASK;
      if ((wr_dh || wr_dl) && !s_q.program_control[nvm_ctrl_pkg::PC_LATCH]
          && (special || !s_q.divider_written))
      begin
        if (wr_dh)
          s_d.divider[9:8] = w[1:0];
        else
          s_d.divider[7:0] = w;
        s_d.divider_written = !special;
      end
      if (wr_pc)
      begin
        if (hv)
        begin
          pc_new[nvm_ctrl_pkg::PC_HV] = w[nvm_ctrl_pkg::PC_HV];
        end
        else
        begin
          pc_new[7:1] = w[7:1] & nvm_ctrl_pkg::PC_WRITABLE_MASK[7:1];
          if (s_q.module_config[nvm_ctrl_pkg::MC_PROTECT_LOCK])
            pc_new[nvm_ctrl_pkg::PC_BULK_PROTECT] =
              s_q.program_control[nvm_ctrl_pkg::PC_BULK_PROTECT];
          if (s_q.divider == 10'h000)
            pc_new[nvm_ctrl_pkg::PC_LATCH] = s_q.program_control[nvm_ctrl_pkg::PC_LATCH];
          // hv only once latch already armed
          pc_new[nvm_ctrl_pkg::PC_HV] = w[nvm_ctrl_pkg::PC_HV]
                                     && s_q.program_control[nvm_ctrl_pkg::PC_LATCH]
                                     && pc_new[nvm_ctrl_pkg::PC_LATCH];
        end
        if (!pc_new[nvm_ctrl_pkg::PC_LATCH])
          s_d.latch_loaded = 1'b0;
      end
      // array writes load latches only with hv clear
      if (arr_write_accept_o)
      begin
        s_d.latch.addr = arr_word_i ? {arr_addr_i[11:1], 1'b0} : arr_addr_i;
        s_d.latch.data = arr_wdata_i;
        s_d.latch.word = arr_word_i && !arr_addr_i[0];
        s_d.latch_loaded = 1'b1;
      end

      // Wait gating only stalls the prescaler; a cycle in flight resumes later
      // Prescaler gives one tick per divider value of clk_i cycles
      if (!s_q.cycle_active)
      begin
        s_d.prescale = 10'h001;
        s_d.ticks = 10'h000;
      end
      else if (module_clk_en_o)
      begin
        if (s_q.prescale >= s_q.divider)
        begin
          s_d.prescale = 10'h001;
          tick = 1'b1;
        end
        else
          s_d.prescale = s_q.prescale + 10'h001;
      end
      if (tick)
      begin
        if (s_q.ticks >= 10'(nvm_ctrl_pkg::PROGRAM_DELAY_TICKS - 1))
          s_d.cycle_done = 1'b1;
        else
          s_d.ticks = s_q.ticks + 10'h001;
      end
      // start only with nonzero divider, unprotected target
      s_d.cycle_active = hv && !protected_target && s_q.divider != 10'h000 && !s_q.cycle_done;
      // Done holds until the enable drops, so a finished cycle never reruns
      if (!hv)
        s_d.cycle_done = 1'b0;
      if (s_q.cycle_done && s_q.program_control[nvm_ctrl_pkg::PC_SELF_CLEAR] && hv)
        pc_new[nvm_ctrl_pkg::PC_HV] = 1'b0;
      s_d.program_control = pc_new;
    end

    s_d.rdata = 8'h00;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        nvm_ctrl_pkg::OFF_DIV_HIGH: s_d.rdata = {6'h00, s_q.divider[9:8]};
        nvm_ctrl_pkg::OFF_DIV_LOW: s_d.rdata = s_q.divider[7:0];
        nvm_ctrl_pkg::OFF_MODULE_CONFIG: s_d.rdata = s_q.module_config;
        nvm_ctrl_pkg::OFF_BLOCK_PROTECT: s_d.rdata = s_q.block_protect;
        nvm_ctrl_pkg::OFF_PROGRAM_CONTROL: s_d.rdata = s_q.program_control;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
      s_q.module_config[3:0] <= nvm_ctrl_pkg::MC_LOW_RESET;
      s_q.block_protect <= nvm_ctrl_pkg::BLOCK_PROTECT_RESET;
      s_q.program_control <= nvm_ctrl_pkg::PROGRAM_CONTROL_RESET;
    end
    else
      s_q <= s_d;
  end

  assign shadow_select_o = shadow_vis && arr_addr_i >= nvm_ctrl_pkg::SHADOW_ADDR_HIGH
                        && arr_addr_i <= nvm_ctrl_pkg::SHADOW_ADDR_LOW;
  // array writes ignored while hv set
  assign arr_write_accept_o = arr_wr_i && s_q.loaded && !hv
                           && s_q.program_control[nvm_ctrl_pkg::PC_LATCH]
                           && arr_addr_i >= nvm_ctrl_pkg::ARRAY_BASE;
  assign module_clk_en_o = !(wait_mode_i && s_q.module_config[nvm_ctrl_pkg::MC_STOP_IN_WAIT]);
  assign hv_on_o = s_q.cycle_active;
  assign op_kind_o = kind;
  assign op_addr_o = s_q.latch.addr;
  assign op_data_o = s_q.latch.data;
  assign op_word_o = s_q.latch.word;
  assign reg_rdata_o = s_q.rdata;
  assign flash_program_open_o = s_q.module_config[nvm_ctrl_pkg::MC_FLASH_OPEN];
  assign debug_lockout_disable_o = s_q.module_config[nvm_ctrl_pkg::MC_DEBUG_LOCKOUT_DISABLE];
endmodule

// Flags an address that falls inside one protected window
module nvm_range_hit #(
  parameter logic [11:0] LO = 12'h000,
  parameter logic [11:0] HI = 12'hFFF
) (
  input wire logic [11:0] addr_i,
  input wire logic en_i,
  output logic hit_o
);
  assign hit_o = en_i && addr_i >= LO && addr_i <= HI;
endmodule

// [verif/nvm_ctrl_assertions.sv]
`timescale 1ns/1ps
module nvm_ctrl_assertions (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic normal_mode_flag_i,
  input wire logic wait_mode_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [11:0] arr_addr_i,
  input wire logic shadow_select_o,
  input wire logic arr_write_accept_o,
  input wire logic hv_on_o,
  input wire logic [1:0] op_kind_o,
  input wire logic [11:0] op_addr_o,
  input wire logic [15:0] op_data_o,
  input wire logic op_word_o,
  input wire logic module_clk_en_o,
  input wire logic flash_program_open_o,
  input wire logic debug_lockout_disable_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_shadow_map;
    shadow_select_o |-> arr_addr_i inside {12'hFC0, 12'hFC1};
  endproperty
  a_shadow_map: assert property (p_shadow_map) else $error("shadow select off word");
  property p_clk_gate;
    !wait_mode_i |-> module_clk_en_o;
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("clock gated outside wait");
  // A cycle starts two edges after the control write that sets the enable
  property p_hv_start;
    $rose(hv_on_o) |-> $past(reg_wr_i, 2) && ($past(reg_addr_i, 2) == 8'hF3)
      && (($past(reg_wdata_i, 2) & 8'h01) != 8'h00);
  endproperty
  a_hv_start: assert property (p_hv_start) else $error("cycle start without enable");
  property p_hold;
    hv_on_o && $past(hv_on_o) |-> $stable(op_addr_o) && $stable(op_data_o) && $stable(op_word_o);
  endproperty
  a_hold: assert property (p_hold) else $error("latched target moved");
  property p_kind_freeze;
    hv_on_o && $past(hv_on_o) |-> $stable(op_kind_o);
  endproperty
  a_kind_freeze: assert property (p_kind_freeze) else $error("erase kind moved");
  property p_accept_range;
    arr_write_accept_o |-> arr_addr_i >= 12'hC00;
  endproperty
  a_accept_range: assert property (p_accept_range) else $error("latched outside array");
  property p_word_align;
    op_word_o |-> !op_addr_o[0];
  endproperty
  a_word_align: assert property (p_word_align) else $error("odd word target");
  // Three normal samples cover the two-stage mode synchroniser
  property p_normal_cfg;
    normal_mode_flag_i && $past(normal_mode_flag_i) && $past(normal_mode_flag_i, 2)
      && $past(rst_n_i) && $past(rst_n_i, 2) |=> $stable(debug_lockout_disable_o)
      && (flash_program_open_o <= $past(flash_program_open_o));
  endproperty
  a_normal_cfg: assert property (p_normal_cfg) else $error("config changed in normal");
  c_run: cover property ($rose(hv_on_o));
  c_accept: cover property (arr_write_accept_o);
  c_shadow: cover property (shadow_select_o);
  c_gate: cover property (!module_clk_en_o);
endmodule

bind nvm_program_erase_ctrl nvm_ctrl_assertions u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .normal_mode_flag_i(normal_mode_flag_i), .wait_mode_i(wait_mode_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .arr_addr_i(arr_addr_i), .shadow_select_o(shadow_select_o),
  .arr_write_accept_o(arr_write_accept_o), .hv_on_o(hv_on_o), .op_kind_o(op_kind_o),
  .op_addr_o(op_addr_o), .op_data_o(op_data_o), .op_word_o(op_word_o),
  .module_clk_en_o(module_clk_en_o), .flash_program_open_o(flash_program_open_o),
  .debug_lockout_disable_o(debug_lockout_disable_o));

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] SHADOW = 16'h8001;
  localparam int TICKS = nvm_ctrl_pkg::PROGRAM_DELAY_TICKS;
  localparam logic [7:0] MC = nvm_ctrl_pkg::OFF_MODULE_CONFIG;
  localparam logic [7:0] BP = nvm_ctrl_pkg::OFF_BLOCK_PROTECT;
  localparam logic [7:0] PC = nvm_ctrl_pkg::OFF_PROGRAM_CONTROL;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic normal_mode_flag_i = 1'b1;
  logic wait_mode_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [11:0] arr_addr_i = 12'h000;
  logic [15:0] arr_wdata_i = 16'h0000;
  logic arr_wr_i = 1'b0;
  logic arr_word_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [11:0] op_addr_o;
  logic [15:0] op_data_o;
  logic [1:0] op_kind_o;
  logic shadow_select_o, arr_write_accept_o, hv_on_o, op_word_o;
  logic module_clk_en_o, flash_program_open_o, debug_lockout_disable_o;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;

  nvm_program_erase_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .normal_mode_flag_i(normal_mode_flag_i), .wait_mode_i(wait_mode_i),
    .shadow_word_i(SHADOW), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .arr_addr_i(arr_addr_i), .arr_wdata_i(arr_wdata_i), .arr_wr_i(arr_wr_i),
    .arr_word_i(arr_word_i), .shadow_select_o(shadow_select_o),
    .arr_write_accept_o(arr_write_accept_o), .hv_on_o(hv_on_o), .op_kind_o(op_kind_o),
    .op_addr_o(op_addr_o), .op_data_o(op_data_o), .op_word_o(op_word_o),
    .module_clk_en_o(module_clk_en_o), .flash_program_open_o(flash_program_open_o),
    .debug_lockout_disable_o(debug_lockout_disable_o));

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  task automatic complete_run;
    $display("Checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(n, {8'h00, e}, {8'h00, reg_rdata_o});
    @(posedge clk_i);
  endtask

  task automatic awr(input logic [11:0] a, input logic [15:0] d, input logic w, input logic e);
    arr_addr_i <= a;
    arr_wdata_i <= d;
    arr_word_i <= w;
    arr_wr_i <= 1'b1;
    #1 chk("write accept", {15'h0, e}, {15'h0, arr_write_accept_o});
    @(posedge clk_i);
    arr_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic bit_chk(input string n, input logic e, input logic g);
    chk(n, {15'h0, e}, {15'h0, g});
  endtask

  // Twelve cycles is far shorter than a full cycle, so a run still shows
  task automatic hv_chk(input logic e);
    repeat (12) @(posedge clk_i);
    #1 bit_chk("hv on", e, hv_on_o);
    @(posedge clk_i);
  endtask

  task automatic sh(input logic [11:0] a, input logic e);
    arr_addr_i <= a;
    #1 bit_chk("shadow select", e, shadow_select_o);
    @(posedge clk_i);
  endtask

  task automatic t_reset;
    rd("config reset", MC, {SHADOW[15:12], nvm_ctrl_pkg::MC_LOW_RESET});
    rd("protect reset", BP, nvm_ctrl_pkg::BLOCK_PROTECT_RESET);
    rd("control reset", PC, nvm_ctrl_pkg::PROGRAM_CONTROL_RESET);
    rd("divider high", 8'hEE, {6'h00, SHADOW[9:8]});
    rd("divider low", 8'hEF, SHADOW[7:0]);
    rd("unmapped", 8'hF2, 8'h00);
    bit_chk("debug lockout", SHADOW[15], debug_lockout_disable_o);
    wr(8'hEF, 8'h01);
    wr(8'hEE, 8'h03);
    wr(8'hEF, 8'h02);
    rd("divider low once", 8'hEF, 8'h01);
    rd("divider high once", 8'hEE, 8'h00);
  endtask

  task automatic t_program;
    int t0;
    wr(BP, 8'h00);
    rd("protect open", BP, 8'h00);
    wr(PC, 8'h20);
    wr(PC, 8'h23);
    rd("latch only", PC, 8'h22);
    awr(12'hC02, 16'hA55A, 1'b1, 1'b1);
    chk("op addr", {4'h0, 12'hC02}, {4'h0, op_addr_o});
    chk("op data", 16'hA55A, op_data_o);
    bit_chk("op word", 1'b1, op_word_o);
    wr(PC, 8'h23);
    t0 = cyc;
    hv_chk(1'b1);
    wr(PC, 8'h2F);
    rd("control frozen", PC, 8'h23);
    wr(BP, 8'h1F);
    rd("protect frozen", BP, 8'h00);
    awr(12'hC10, 16'h1234, 1'b0, 1'b0);
    chk("latched data kept", 16'hA55A, op_data_o);
    do
    begin
      @(posedge clk_i);
      #1;
    end
    while (hv_on_o === 1'b1 && cyc - t0 < 2 * TICKS);
    bit_chk("self timed", (cyc - t0 >= TICKS) && (cyc - t0 <= TICKS + 12), 1'b1);
    @(posedge clk_i);
    rd("self clear", PC, 8'h22);
    wr(PC, 8'h20);
  endtask

  task automatic t_protect;
    logic [7:0] pv [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h80};
    logic [11:0] av [6] = '{12'hFFF, 12'hF80, 12'hF7F, 12'hE00, 12'hDFF, 12'hFC0};
    for (int i = 0; i < 6; i++)
    begin
      wr(BP, pv[i]);
      wr(PC, 8'h22);
      awr(av[i], 16'h00F0, 1'b0, 1'b1);
      wr(PC, 8'h23);
      hv_chk(1'b0);
      rd("no self clear", PC, 8'h23);
      wr(PC, 8'h22);
      wr(PC, 8'h20);
    end
  endtask

  task automatic t_erase;
    logic [7:0] cv [6] = '{8'h00, 8'h04, 8'h0C, 8'h14, 8'h1C, 8'h08};
    logic [1:0] kv [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
    wr(BP, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(PC, cv[i]);
      #1 chk("erase kind", {14'h0, kv[i]}, {14'h0, op_kind_o});
      @(posedge clk_i);
    end
    wr(PC, 8'h86);
    awr(12'hC00, 16'h0000, 1'b0, 1'b1);
    wr(PC, 8'h87);
    hv_chk(1'b0);
    wr(PC, 8'h86);
    wr(PC, 8'h06);
    wr(PC, 8'h07);
    hv_chk(1'b1);
    wr(PC, 8'h06);
    awr(12'hC20, 16'hFFFF, 1'b0, 1'b1);
    wr(PC, 8'h00);
  endtask

  task automatic t_modes;
    sh(12'hFC1, 1'b1);
    sh(12'hFC2, 1'b0);
    wr(MC, 8'h9E);
    rd("lock set", MC, 8'h8E);
    bit_chk("flash closed", 1'b0, flash_program_open_o);
    wr(MC, 8'h8C);
    rd("lock once", MC, 8'h8E);
    wr(BP, 8'h9F);
    rd("protect locked", BP, 8'h00);
    normal_mode_flag_i <= 1'b0;
    wait_mode_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 bit_chk("clock gated", 1'b0, module_clk_en_o);
    @(posedge clk_i);
    wr(MC, 8'hD8);
    rd("special config", MC, 8'hD8);
    bit_chk("flash open", 1'b1, flash_program_open_o);
    bit_chk("clock running", 1'b1, module_clk_en_o);
    sh(12'hFC0, 1'b0);
    wr(PC, 8'h06);
    awr(12'hC00, 16'h0000, 1'b0, 1'b1);
    wr(PC, 8'h07);
    hv_chk(1'b0);
    wr(PC, 8'h06);
    wr(PC, 8'h00);
    wr(8'hEF, 8'h00);
    wr(8'hEE, 8'h00);
    rd("divider special", 8'hEF, 8'h00);
    wr(PC, 8'h02);
    rd("latch refused", PC, 8'h00);
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_program();
    t_protect();
    t_erase();
    t_modes();
    complete_run();
  end

  // The whole sequence needs well under two thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    complete_run();
  end
endmodule
